// *** common/frpa_map.vh ***
// constants of the flash read, prefetch and arbitration block
// assumes inclusion by its bare name from the rtl files
`ifndef FRPA_MAP_VH
`define FRPA_MAP_VH

// access control register, byte address on the register bus
`define FRPA_ACR_ADDR 32'h40022000
`define FRPA_ACR_RESET 32'h00000030

// field positions inside the access control register
`define FRPA_LAT_LSB 0
`define FRPA_LAT_MSB 2
`define FRPA_HALF_BIT 3
`define FRPA_PFE_BIT 4
`define FRPA_PFS_BIT 5

// field reset values
`define FRPA_LAT_RESET 3'h0
`define FRPA_HALF_RESET 1'b0
`define FRPA_PFE_RESET 1'b1

// main array decode
`define FRPA_MAIN_BASE 32'h08000000
`define FRPA_PAGE_COUNT 256
`define FRPA_PAGE_BYTES 1024

// array read width in bits
`define FRPA_ARR_BITS 64

`endif

// *** rtl/frpa_pfblock.v ***
// one prefetch block: a 64-bit line, its dword address and its state
// assumes clk and asynchronous active-low rst_n of the main block
`timescale 1ns/1ns
module frpa_pfblock #(
  parameter DW_W = 15
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire fill,
  input wire fill_used,
  input wire [DW_W-1:0] fill_dw,
  input wire [63:0] fill_data,
  // state control
  input wire consume,
  input wire flush,
  input wire inv,
  // contents
  output reg valid,
  output reg used,
  output reg [DW_W-1:0] dw,
  output reg [63:0] data
);

  // line storage, a fill wins over any clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      used <= 1'b0;
      dw <= {DW_W{1'b0}};
      data <= 64'h0;
    end else if (fill) begin
      valid <= 1'b1;
      used <= fill_used;
      dw <= fill_dw;
      data <= fill_data;
    end else begin
      if (inv) begin
        valid <= 1'b0;
      end
      if (consume || flush) begin
        used <= 1'b1;
      end
    end
  end

endmodule

// *** rtl/frpa_top.v ***
// flash read side: fetch port with two-block prefetch, data port,
// fixed-priority arbiter, access-time tuner and access control register
// assumes a 64-bit array answering at the end of the held read strobe,
// ports that hold a request until their ready pulse, and pin-level
// program/erase busy and low-power inputs from other clocking
`timescale 1ns/1ns
`include "frpa_map.vh"

module frpa_top #(
  parameter DW_W = 15
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // wishbone register slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [31:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  // instruction fetch port
  input wire IF_REQ,
  input wire [31:0] IF_ADDR,
  output wire [31:0] IF_RDATA,
  output wire IF_READY,
  output wire IF_ERR,
  // literal and data port
  input wire DT_REQ,
  input wire [31:0] DT_ADDR,
  output wire [31:0] DT_RDATA,
  output wire DT_READY,
  output wire DT_ERR,
  // flash array
  output wire ARR_RD,
  output wire ARR_HALF,
  output wire [DW_W-1:0] ARR_ADDR,
  input wire [63:0] ARR_RDATA,
  // system status pins
  input wire PE_BUSY,
  input wire LOW_POWER
);

  // array state codes, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACC = 2'b10;
  // owner codes of an array access, one-hot
  localparam [2:0] OWN_DT = 3'b001;
  localparam [2:0] OWN_IF = 3'b010;
  localparam [2:0] OWN_PF = 3'b100;
  localparam [31:0] MAIN_BYTES = `FRPA_PAGE_COUNT * `FRPA_PAGE_BYTES;
  localparam [31:0] MAIN_BASE = `FRPA_MAIN_BASE;
  localparam [31:0] ACR_ADDR = `FRPA_ACR_ADDR;

  // pin synchronisers
  reg pe_s1_q;
  reg pe_s2_q;
  reg lp_s1_q;
  reg lp_s2_q;
  // register bus
  reg wb_ack_q;
  reg [31:0] wb_dat_q;
  // access control fields
  reg [2:0] lat_q;
  reg half_q;
  reg pfe_q;
  reg pfs_q;
  // array sequencer
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg [2:0] own_q;
  reg [2:0] own_d;
  reg [DW_W-1:0] acc_dw_q;
  reg [DW_W-1:0] acc_dw_d;
  // prefetch pointer
  reg [DW_W-1:0] pf_dw_q;
  reg [DW_W-1:0] pf_dw_d;
  reg pf_act_q;
  reg pf_act_d;
  // port answers
  reg if_ack_q;
  reg if_err_q;
  reg [31:0] if_dat_q;
  reg dt_ack_q;
  reg dt_err_q;
  reg [31:0] dt_dat_q;

  // address decode
  wire [31:0] if_off = IF_ADDR - MAIN_BASE;
  wire [31:0] dt_off = DT_ADDR - MAIN_BASE;
  wire if_in = if_off < MAIN_BYTES;
  wire dt_in = dt_off < MAIN_BYTES;
  wire [DW_W-1:0] if_dw = if_off[DW_W+2:3];
  wire [DW_W-1:0] dt_dw = dt_off[DW_W+2:3];
  wire stall = pe_s2_q | lp_s2_q;

  // prefetch block contents
  wire [1:0] blk_valid;
  wire [1:0] blk_used;
  wire [2*DW_W-1:0] blk_dw;
  wire [127:0] blk_data;
  wire [1:0] blk_free = ~blk_valid | blk_used;

  // buffer lookup for the fetch port
  wire if_idx = if_dw[0];
  wire [DW_W-1:0] hit_dw = if_idx ? blk_dw[2*DW_W-1:DW_W] : blk_dw[DW_W-1:0];
  wire [63:0] hit_line = if_idx ? blk_data[127:64] : blk_data[63:0];
  wire if_hit = pfe_q & blk_valid[if_idx] & (hit_dw == if_dw);

  // pending demands at the ports
  wire if_open = IF_REQ & ~if_ack_q;
  wire dt_open = DT_REQ & ~dt_ack_q;
  wire if_take_hit = if_open & if_in & if_hit & ~stall;
  wire if_need = if_open & if_in & ~if_hit & ~stall;
  wire dt_need = dt_open & dt_in & ~stall;
  wire pf_need = pfe_q & pf_act_q & blk_free[pf_dw_q[0]] & ~stall;

  // arbiter decisions in idle
  wire idle = st_q == ST_IDLE;
  wire gnt_dt = idle & dt_need;
  wire gnt_if = idle & if_need & ~dt_need;
  wire gnt_pf = idle & pf_need & ~dt_need & ~if_need;
  wire acc_done = (st_q == ST_ACC) & (cnt_q == 3'h0) & ~lp_s2_q;
  wire fill_ok = own_q[2] | (own_q[1] & pfe_q);
  wire [31:0] arr_word_if = IF_ADDR[2] ? ARR_RDATA[63:32] : ARR_RDATA[31:0];
  wire [31:0] arr_word_dt = DT_ADDR[2] ? ARR_RDATA[63:32] : ARR_RDATA[31:0];

  // level inputs from pins pass two flops
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pe_s1_q <= 1'b0;
      pe_s2_q <= 1'b0;
      lp_s1_q <= 1'b0;
      lp_s2_q <= 1'b0;
    end else begin
      pe_s1_q <= PE_BUSY;
      pe_s2_q <= pe_s1_q;
      lp_s1_q <= LOW_POWER;
      lp_s2_q <= lp_s1_q;
    end
  end

  // wishbone classic slave, one wait state, unmapped reads give zero
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
    end else begin
      wb_ack_q <= WB_CYC_I & WB_STB_I & ~wb_ack_q;
      if (WB_CYC_I && WB_STB_I && !wb_ack_q) begin
        if (WB_ADR_I[31:2] == ACR_ADDR[31:2]) begin
          wb_dat_q <= {26'h0, pfs_q, pfe_q, half_q, lat_q};
        end else begin
          wb_dat_q <= 32'h0;
        end
      end
    end
  end

  // access control fields, written at the edge that completes the cycle
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lat_q <= `FRPA_LAT_RESET;
      half_q <= `FRPA_HALF_RESET;
      pfe_q <= `FRPA_PFE_RESET;
      pfs_q <= `FRPA_PFE_RESET;
    end else begin
      pfs_q <= pfe_q; // status follows the live enable
      if (WB_CYC_I && WB_STB_I && wb_ack_q && WB_WE_I && WB_SEL_I[0] &&
          WB_ADR_I[31:2] == ACR_ADDR[31:2]) begin
        lat_q <= WB_DAT_I[`FRPA_LAT_MSB:`FRPA_LAT_LSB];
        half_q <= WB_DAT_I[`FRPA_HALF_BIT];
        pfe_q <= WB_DAT_I[`FRPA_PFE_BIT];
      end
    end
  end

  // two direct-mapped prefetch blocks
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : blk
      wire fill_g = acc_done & fill_ok & (acc_dw_q[0] == g);
      wire use_g = if_take_hit & (if_idx == g) & IF_ADDR[2];
      frpa_pfblock #(
        .DW_W(DW_W)
      ) u_blk (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .fill(fill_g),
        .fill_used(own_q[1] & IF_ADDR[2]),
        .fill_dw(acc_dw_q),
        .fill_data(ARR_RDATA),
        .consume(use_g),
        .flush(gnt_if), // a jump frees any stale line
        .inv(lp_s2_q | ~pfe_q),
        .valid(blk_valid[g]),
        .used(blk_used[g]),
        .dw(blk_dw[DW_W*g+DW_W-1:DW_W*g]),
        .data(blk_data[64*g+63:64*g])
      );
    end
  endgenerate

  // array sequencer next state: grant, hold, abort
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    own_d = own_q;
    acc_dw_d = acc_dw_q;
    case (st_q)
      ST_IDLE: begin
        if (gnt_dt || gnt_if || gnt_pf) begin
          st_d = ST_ACC;
          cnt_d = half_q ? 3'h0 : lat_q;
          if (gnt_dt) begin
            own_d = OWN_DT;
            acc_dw_d = dt_dw;
          end else if (gnt_if) begin
            own_d = OWN_IF;
            acc_dw_d = if_dw;
          end else begin
            own_d = OWN_PF;
            acc_dw_d = pf_dw_q;
          end
        end
      end
      ST_ACC: begin
        if (lp_s2_q) begin
          st_d = ST_IDLE;
          own_d = 3'h0;
        end else if (cnt_q == 3'h0) begin
          st_d = ST_IDLE;
          own_d = 3'h0;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: begin
        st_d = ST_IDLE;
        own_d = 3'h0;
      end
    endcase
  end

  // array sequencer registers
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      own_q <= 3'h0;
      acc_dw_q <= {DW_W{1'b0}};
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      own_q <= own_d;
      acc_dw_q <= acc_dw_d;
    end
  end

  // prefetch pointer starts one dword past a fetch miss and steps on each prefetch grant
  always @* begin
    pf_dw_d = pf_dw_q;
    pf_act_d = pf_act_q;
    if (lp_s2_q || !pfe_q) begin
      pf_act_d = 1'b0;
    end else if (gnt_if) begin
      pf_dw_d = if_dw + 1'b1;
      pf_act_d = 1'b1;
    end else if (gnt_pf) begin
      pf_dw_d = pf_dw_q + 1'b1;
    end
  end

  // prefetch pointer registers
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pf_dw_q <= {DW_W{1'b0}};
      pf_act_q <= 1'b0;
    end else begin
      pf_dw_q <= pf_dw_d;
      pf_act_q <= pf_act_d;
    end
  end

  // fetch port answer: buffer hit, array word, or decode error
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      if_ack_q <= 1'b0;
      if_err_q <= 1'b0;
      if_dat_q <= 32'h0;
    end else begin
      if_ack_q <= 1'b0;
      if_err_q <= 1'b0;
      if (if_take_hit) begin
        if_ack_q <= 1'b1;
        if_dat_q <= IF_ADDR[2] ? hit_line[63:32] : hit_line[31:0];
      end else if (acc_done && own_q[1]) begin
        if_ack_q <= 1'b1;
        if_dat_q <= arr_word_if;
      end else if (if_open && !if_in) begin
        if_ack_q <= 1'b1;
        if_err_q <= 1'b1;
        if_dat_q <= 32'h0;
      end
    end
  end

  // data port answer straight from the array
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dt_ack_q <= 1'b0;
      dt_err_q <= 1'b0;
      dt_dat_q <= 32'h0;
    end else begin
      dt_ack_q <= 1'b0;
      dt_err_q <= 1'b0;
      if (acc_done && own_q[0]) begin
        dt_ack_q <= 1'b1;
        dt_dat_q <= arr_word_dt;
      end else if (dt_open && !dt_in) begin
        dt_ack_q <= 1'b1;
        dt_err_q <= 1'b1;
        dt_dat_q <= 32'h0;
      end
    end
  end

  // output drive
  assign WB_ACK_O = wb_ack_q;
  assign WB_DAT_O = wb_dat_q;
  assign IF_READY = if_ack_q;
  assign IF_ERR = if_err_q;
  assign IF_RDATA = if_dat_q;
  assign DT_READY = dt_ack_q;
  assign DT_ERR = dt_err_q;
  assign DT_RDATA = dt_dat_q;
  assign ARR_RD = st_q[1]; // strobe held through the whole access
  assign ARR_HALF = half_q;
  assign ARR_ADDR = acc_dw_q;

endmodule

// *** tb/frpa_array_model.sv ***
// flash array model: one 64-bit line per strobed read
// assumes strobe and dword address come from the read side
`timescale 1ns/1ns
module frpa_array_model #(
  parameter DW_W = 15
) (
  // array side
  input wire clk,
  input wire rd,
  input wire [DW_W-1:0] addr,
  output logic [63:0] rdata
);
  logic [31:0] lo;
  logic [63:0] junk = 64'h0;
  // garbage changing every cycle so stale data never looks right
  always @(posedge clk) junk <= junk + 64'h0123456789abcdef;
  // line content: dword number low, its inverse high
  assign lo = {{(32-DW_W){1'b0}}, addr};
  assign rdata = rd ? {~lo, lo} : junk;
endmodule

// *** tb/frpa_top_assertions.sv ***
// checker for the flash read side on top-level pins
// assumes one clock domain and the register bus select tied high
`timescale 1ns/1ns
`include "frpa_map.vh"
module frpa_checker (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // register bus
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [31:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire WB_ACK_O,
  // ports
  input wire [31:0] IF_ADDR,
  input wire IF_READY,
  input wire IF_ERR,
  input wire DT_REQ,
  input wire [31:0] DT_ADDR,
  input wire DT_READY,
  input wire DT_ERR,
  // array and status
  input wire ARR_RD,
  input wire ARR_HALF,
  input wire PE_BUSY,
  input wire LOW_POWER
);
  localparam logic [31:0] TOP = `FRPA_MAIN_BASE + `FRPA_PAGE_COUNT * `FRPA_PAGE_BYTES;
  logic [2:0] lat_q;
  logic half_q;
  logic [7:0] run_q;
  wire [3:0] len = half_q ? 4'h1 : {1'b0, lat_q} + 4'h1;
  wire if_out = IF_ADDR < `FRPA_MAIN_BASE || IF_ADDR >= TOP;
  wire dt_out = DT_ADDR < `FRPA_MAIN_BASE || DT_ADDR >= TOP;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // shadow of the tuner fields, taken when ack is sampled
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lat_q <= 3'h0;
      half_q <= 1'b0;
    end else if (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == `FRPA_ACR_ADDR) begin
      lat_q <= WB_DAT_I[2:0];
      half_q <= WB_DAT_I[3];
    end
  end
  // length of the current run of strobe cycles
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) run_q <= 8'h0;
    else run_q <= ARR_RD ? run_q + 8'h1 : 8'h0;
  end
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_take: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  a_half_pin: assert property (ARR_HALF == half_q)
    else $error("half-cycle pin wrong");
  // a strobe cut short by a low-power abort is legal, so leave those runs out
  a_strobe_len: assert property (!ARR_RD && run_q != 8'h0 && !$past(LOW_POWER, 3) |-> run_q % len == 0)
    else $error("strobe length wrong");
  a_if_range: assert property (IF_READY |-> IF_ERR == if_out)
    else $error("fetch range error wrong");
  a_dt_range: assert property (DT_READY |-> DT_ERR == dt_out)
    else $error("data range error wrong");
  a_lp_quiet: assert property (LOW_POWER [*5] |-> !ARR_RD && !IF_READY && !DT_READY)
    else $error("access during low power");
  a_pe_stall: assert property (PE_BUSY [*5] |-> !IF_READY && !DT_READY)
    else $error("read answered while busy");
  a_dt_bound: assert property ($rose(DT_REQ) |-> ##[1:16] DT_READY)
    else $error("data port starved");
  // main scenarios
  c_hit: cover property (IF_READY && !IF_ERR && !ARR_RD);
  c_race: cover property (DT_READY && run_q == 8'h0);
  c_half: cover property (ARR_HALF && ARR_RD);
endmodule
bind frpa_top frpa_checker frpa_checker_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .IF_ADDR(IF_ADDR), .IF_READY(IF_READY), .IF_ERR(IF_ERR), .DT_REQ(DT_REQ), .DT_ADDR(DT_ADDR),
  .DT_READY(DT_READY), .DT_ERR(DT_ERR), .ARR_RD(ARR_RD), .ARR_HALF(ARR_HALF), .PE_BUSY(PE_BUSY),
  .LOW_POWER(LOW_POWER));

// *** tb/tb_frpa_top.sv ***
// bench for the flash read side: register, fetch and data port tests
// assumes the array model and the bound checker
`timescale 1ns/1ns
`include "frpa_map.vh"
module tb_frpa_top;
  localparam logic [31:0] TOP = `FRPA_MAIN_BASE + `FRPA_PAGE_COUNT * `FRPA_PAGE_BYTES;
  localparam logic [31:0] ACR = `FRPA_ACR_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic if_req = 1'b0;
  logic dt_req = 1'b0;
  logic [31:0] if_addr = 32'h0;
  logic [31:0] dt_addr = 32'h0;
  logic pe = 1'b0;
  logic lp = 1'b0;
  wire [31:0] rdat, if_rdata, dt_rdata;
  wire ack, if_rdy, if_err, dt_rdy, dt_err, arr_rd;
  wire [14:0] arr_addr;
  wire [63:0] arr_rdata;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] r;
  int n1;
  int n2;
  // clock at 25 MHz
  always #20 clk = ~clk;
  frpa_top frpa_top_i (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IF_REQ(if_req),
    .IF_ADDR(if_addr), .IF_RDATA(if_rdata), .IF_READY(if_rdy), .IF_ERR(if_err), .DT_REQ(dt_req),
    .DT_ADDR(dt_addr), .DT_RDATA(dt_rdata), .DT_READY(dt_rdy), .DT_ERR(dt_err), .ARR_RD(arr_rd),
    .ARR_HALF(), .ARR_ADDR(arr_addr), .ARR_RDATA(arr_rdata), .PE_BUSY(pe), .LOW_POWER(lp));
  frpa_array_model frpa_array_model_i (.clk(clk), .rd(arr_rd), .addr(arr_addr), .rdata(arr_rdata));
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // a wait that ran out ends the run
  task automatic hang(input int n);
    if (n >= 100) begin
      n_mismatch++;
      $display("unexpected at %0t: no answer", $time);
      print_verdict;
    end
  endtask
  // expected word: dword number low, inverse high
  function automatic logic [31:0] ew(input logic [31:0] a);
    logic [31:0] lo;
    lo = (a - `FRPA_MAIN_BASE) >> 3;
    return a[2] ? ~lo : lo;
  endfunction
  // one classic register bus cycle, read data into r
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    hang(n);
  endtask
  // one port read, checks word, error and cycles to answer
  task automatic xfer(input logic p, input logic [31:0] a, input int nx, output int n);
    logic [32:0] x;
    x = (a < `FRPA_MAIN_BASE || a >= TOP) ? {1'b1, 32'h0} : {1'b0, ew(a)};
    @(posedge clk);
    if (p) begin
      dt_req <= 1'b1;
      dt_addr <= a;
    end else begin
      if_req <= 1'b1;
      if_addr <= a;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((p ? dt_rdy : if_rdy) !== 1'b1 && n < 100);
    chk(p ? {dt_err, dt_rdata} : {if_err, if_rdata}, x);
    if (nx > 0) chk(n, nx);
    if (p) dt_req <= 1'b0;
    else if_req <= 1'b0;
    hang(n);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, ACR, 32'h0);
    chk(r, 32'h30);
    wb(0, ACR + 32'h4, 32'h0);
    chk(r, 32'h0);
    wb(1, ACR, 32'hffffffd0);
    wb(0, ACR, 32'h0);
    chk(r, 32'h30);
    $display("test registers done");
    for (int i = 0; i < 4; i++) xfer(0, `FRPA_MAIN_BASE + 4 * i, i == 0 ? 3 : 2, n1);
    xfer(0, 32'h08040000, 2, n1);
    xfer(1, 32'h0803fff8, 3, n1);
    xfer(1, 32'h1fffe800, 2, n1);
    $display("test prefetch and decode done");
    wb(1, ACR, 32'h12);
    xfer(1, 32'h08000400, 5, n1);
    xfer(0, 32'h08000800, 5, n1);
    wb(0, ACR, 32'h0);
    chk(r, 32'h32);
    fork
      xfer(0, 32'h08001000, 0, n1);
      xfer(1, 32'h08002000, 5, n2);
    join
    chk(n1 > n2, 1);
    wb(1, ACR, 32'h1a);
    xfer(1, 32'h08000018, 3, n1);
    $display("test latency, priority and half cycle done");
    wb(1, ACR, 32'h01);
    wb(0, ACR, 32'h0);
    chk(r, 32'h01);
    for (int i = 0; i < 2; i++) xfer(0, 32'h08000100 + 4 * i, 4, n1);
    $display("test prefetch off done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) pe <= 1'b1;
      else lp <= 1'b1;
      repeat (3) @(posedge clk);
      fork
        xfer(0, 32'h08000200 + 8 * k, 0, n1);
        begin
          repeat (12) @(posedge clk);
          pe <= 1'b0;
          lp <= 1'b0;
        end
      join
      chk(n1 > 12, 1);
    end
    $display("test stalls done");
    print_verdict;
  end
endmodule
